// ===== hw/accl_pkg.sv
// constants and types for the current-limit and auto-compensation control block
// ---------------------------------------------------------------------------
// Contract
// - sense output current only in a window of each switching period, via winding resistance
// - winding-resistance sensing is the only method; no switch on-resistance sensing
// - no measurement during a configurable blanking time after an edge; default 480 ns
// - full-scale sensing range selectable among 25, 35 and 50 mV
// - reset defaults: down-slope, output-referenced, 50 mV threshold, 50 mV range, 7 violations
// - custom limit threshold and fault response set only over the serial bus
// - strap low disables; open single unstored; high single stored; power-good after run, 100%
// - strap resistor code sets store, repeat, 1 s or 1 min period, pg timing, gain
// - routine runs once after ramp or periodically while regulating
// - store mode saves coefficients in nonvolatile store and returns them on readback
// - repeat mode stores only the first run, applies newest periodic results unstored
// - saved coefficients are loaded and used on each later ramp; code clears store_valid at reset, so none are loaded after a reset
// - stored values cleared only by disabling store, refused while output enabled
// - trigger while enabled in store mode stores next run, overwriting old values
// - with auto compensation off, use the configuration-store parameters
// - pg after first run when set so, ignoring delay; otherwise apply the delay
// - results scaled by configured gain: 100% fastest, 10% lowest jitter
// - fast-transient path bypasses the main loop outside regulation limits
// - undershoot forces upper switch on; overshoot forces lower switch on
// ---------------------------------------------------------------------------
package accl_pkg;
   // ---------------------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int BLANK_NS = 480;
   localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int TICK_US_CYC = CLK_MHZ;
   localparam int PERIOD_1S_US = 1000000;
   localparam int PERIOD_1MIN_US = 60000000;
   // ---------------------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------------------
   localparam logic [7:0] OFS_OVERCURRENT_LIMIT_CFG = 8'h00;
   localparam logic [7:0] OFS_COMP_CFG = 8'h04;
   localparam logic [7:0] OFS_COMP_CMD = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_COEFF_RD = 8'h10;
   localparam logic [7:0] OFS_PG_DELAY = 8'h14;
   localparam logic [7:0] OFS_USER_COEFF = 8'h18;
   // ---------------------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------------------
   localparam int OVERCURRENT_LIMIT_THR_LSB = 0;
   localparam int OVERCURRENT_LIMIT_RANGE_LSB = 8;
   localparam int OVERCURRENT_LIMIT_VIOL_LSB = 12;
   localparam int OVERCURRENT_LIMIT_BLANK_LSB = 16;
   localparam int OVERCURRENT_LIMIT_UPSLOPE_BIT = 31;
   localparam logic [7:0] RST_THR_MV = 8'h32;
   localparam logic [3:0] RST_VIOL = 4'h7;
   localparam int COEFF_W = 16;
   localparam int GAIN_FULL_PCT = 100;
   localparam logic [6:0] GAIN_HALF_PCT = 7'h32;
   localparam logic [6:0] GAIN_MIN_PCT = 7'h0a;
   localparam logic [3:0] STRAP_LOW = 4'h0;
   localparam logic [3:0] STRAP_OPEN = 4'h1;
   localparam logic [3:0] STRAP_HIGH = 4'h2;

   typedef enum logic [1:0] {
      RANGE_25MV = 2'b00,
      RANGE_35MV = 2'b01,
      RANGE_50MV = 2'b10
   } accl_range_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_REG = 2'b10
   } accl_state_t;

   typedef struct packed {
      logic enable;
      logic store;
      logic repeat_run;
      logic minute_period;
      logic pg_after_comp;
      logic [6:0] gain_pct;
   } accl_comp_cfg_t;

   typedef struct packed {
      logic upper_on;
      logic lower_on;
      logic bypass;
   } accl_drive_t;

   // strap code: 0 low, 1 open, 2 high, 3..34 resistor steps from lowest upward
   function automatic accl_comp_cfg_t accl_decode_strap(input logic [5:0] code);
      accl_comp_cfg_t c;
      logic [4:0] idx;
      c = '0;
      idx = 5'(code - 6'h03);
      c.gain_pct = 7'(GAIN_FULL_PCT);
      c.pg_after_comp = 1'b1;
      if (code == 6'(STRAP_LOW)) begin
         c.enable = 1'b0;
      end else if (code == 6'(STRAP_OPEN) || code == 6'(STRAP_HIGH)) begin
         c.enable = 1'b1;
         c.store = (code == 6'(STRAP_HIGH));
      end else begin
         c.enable = 1'b1;
         c.store = idx[0];
         c.repeat_run = idx[1];
         c.pg_after_comp = ~idx[2];
         c.minute_period = idx[3];
         if (idx[4]) begin
            c.gain_pct = GAIN_HALF_PCT;
         end
      end
      return c;
   endfunction
endpackage : accl_pkg

// ===== hw/accl_ctrl.sv
// current-limit, auto-compensation sequencing and fast-transient control with apb registers
module accl_ctrl #(
   parameter int VIOL_W = 4,
   parameter int US_PER_1S = accl_pkg::PERIOD_1S_US,
   parameter int US_PER_1MIN = accl_pkg::PERIOD_1MIN_US
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] comp_config_strap,
   input wire logic strap_sample,
   input wire logic sw_edge,
   input wire logic period_start,
   input wire logic [7:0] limit_sense_voltage,
   input wire logic output_enabled,
   input wire logic ramp_done,
   input wire logic pg_delay_done,
   input wire logic comp_done,
   input wire logic [accl_pkg::COEFF_W-1:0] comp_result,
   input wire logic [accl_pkg::COEFF_W-1:0] nv_coeff,
   input wire logic below_lower_limit,
   input wire logic above_upper_limit,
   output logic comp_start,
   output logic nv_write,
   output logic [accl_pkg::COEFF_W-1:0] nv_wdata,
   output logic [accl_pkg::COEFF_W-1:0] active_coeff,
   output logic power_good_out,
   output logic overcurrent_limit,
   output accl_pkg::accl_drive_t fast_transient_path
);
   // ---------------------------------------------------------------------------
   // apb register file
   // ---------------------------------------------------------------------------
   logic [7:0] thr_mv, next_thr_mv;
   accl_pkg::accl_range_t range_sel, next_range_sel;
   logic [VIOL_W-1:0] viol_allowed, next_viol_allowed;
   logic [7:0] blank_cyc, next_blank_cyc;
   logic upslope, next_upslope;
   accl_pkg::accl_comp_cfg_t cfg, next_cfg;
   logic [accl_pkg::COEFF_W-1:0] user_coeff, next_user_coeff;
   logic store_valid, next_store_valid;
   logic [31:0] next_prdata;
   logic trig, wr, rd, refused, next_refused;
   logic [accl_pkg::COEFF_W-1:0] stored;
   accl_pkg::accl_state_t state, next_state;

   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign trig = wr && paddr == accl_pkg::OFS_COMP_CMD && pwdata[0];

   function automatic logic mapped(input logic [7:0] a);
      return a == accl_pkg::OFS_OVERCURRENT_LIMIT_CFG || a == accl_pkg::OFS_COMP_CFG ||
         a == accl_pkg::OFS_COMP_CMD || a == accl_pkg::OFS_STATUS ||
         a == accl_pkg::OFS_COEFF_RD || a == accl_pkg::OFS_PG_DELAY ||
         a == accl_pkg::OFS_USER_COEFF;
   endfunction
   assign pslverr = psel & penable & ~mapped(paddr);

   always_comb begin
      next_thr_mv = thr_mv;
      next_range_sel = range_sel;
      next_viol_allowed = viol_allowed;
      next_blank_cyc = blank_cyc;
      next_upslope = upslope;
      next_cfg = cfg;
      next_user_coeff = user_coeff;
      next_refused = refused;
      next_prdata = prdata;
      if (strap_sample) begin
         next_cfg = accl_pkg::accl_decode_strap(comp_config_strap);
      end
      if (wr && paddr == accl_pkg::OFS_OVERCURRENT_LIMIT_CFG) begin
         next_thr_mv = pwdata[accl_pkg::OVERCURRENT_LIMIT_THR_LSB +: 8];
         if (pwdata[accl_pkg::OVERCURRENT_LIMIT_RANGE_LSB +: 2] != 2'b11) begin
            next_range_sel = accl_pkg::accl_range_t'(pwdata[accl_pkg::OVERCURRENT_LIMIT_RANGE_LSB +: 2]);
         end
         next_viol_allowed = pwdata[accl_pkg::OVERCURRENT_LIMIT_VIOL_LSB +: VIOL_W];
         next_blank_cyc = pwdata[accl_pkg::OVERCURRENT_LIMIT_BLANK_LSB +: 8];
         next_upslope = pwdata[accl_pkg::OVERCURRENT_LIMIT_UPSLOPE_BIT];
      end
      if (wr && paddr == accl_pkg::OFS_COMP_CFG) begin
         next_refused = 1'b0;
         next_cfg.enable = pwdata[0];
         next_cfg.repeat_run = pwdata[2];
         next_cfg.minute_period = pwdata[3];
         next_cfg.pg_after_comp = pwdata[4];
         next_cfg.gain_pct = (pwdata[14:8] < accl_pkg::GAIN_MIN_PCT) ? accl_pkg::GAIN_MIN_PCT :
            (pwdata[14:8] > 7'(accl_pkg::GAIN_FULL_PCT)) ? 7'(accl_pkg::GAIN_FULL_PCT) :
            pwdata[14:8];
         if (!pwdata[1] && cfg.store && output_enabled) begin
            next_refused = 1'b1;
         end else begin
            next_cfg.store = pwdata[1];
         end
      end
      if (wr && paddr == accl_pkg::OFS_USER_COEFF) begin
         next_user_coeff = pwdata[accl_pkg::COEFF_W-1:0];
      end
      if (psel && !penable && !pwrite) begin
         case (paddr)
            accl_pkg::OFS_OVERCURRENT_LIMIT_CFG: next_prdata = {upslope, 7'h00, blank_cyc,
               4'(viol_allowed), 2'h0, range_sel, thr_mv};
            accl_pkg::OFS_COMP_CFG: next_prdata = {17'h0, cfg.gain_pct, 3'h0, cfg.pg_after_comp,
               cfg.minute_period, cfg.repeat_run, cfg.store, cfg.enable};
            accl_pkg::OFS_STATUS: next_prdata = {26'h0, refused, store_valid,
               overcurrent_limit, power_good_out, state};
            accl_pkg::OFS_COEFF_RD: next_prdata = {16'h0, stored};
            accl_pkg::OFS_USER_COEFF: next_prdata = {16'h0, user_coeff};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         thr_mv <= accl_pkg::RST_THR_MV;
         range_sel <= accl_pkg::RANGE_50MV;
         viol_allowed <= VIOL_W'(accl_pkg::RST_VIOL);
         blank_cyc <= 8'(accl_pkg::BLANK_CYC);
         upslope <= 1'b0;
         cfg <= '0;
         user_coeff <= '0;
         refused <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         thr_mv <= next_thr_mv;
         range_sel <= next_range_sel;
         viol_allowed <= next_viol_allowed;
         blank_cyc <= next_blank_cyc;
         upslope <= next_upslope;
         cfg <= next_cfg;
         user_coeff <= next_user_coeff;
         refused <= next_refused;
         prdata <= next_prdata;
      end
   end

   // ---------------------------------------------------------------------------
   // current limit: blanking, window sampling, violation count
   // ---------------------------------------------------------------------------
   logic [7:0] blank_cnt, next_blank_cnt;
   logic [VIOL_W-1:0] viol_cnt, next_viol_cnt;
   logic viol_seen, next_viol_seen, next_ocl;
   logic [7:0] sense_clip;

   always_comb begin
      case (range_sel)
         accl_pkg::RANGE_25MV: sense_clip = (limit_sense_voltage > 8'h19) ? 8'h19 :
            limit_sense_voltage;
         accl_pkg::RANGE_35MV: sense_clip = (limit_sense_voltage > 8'h23) ? 8'h23 :
            limit_sense_voltage;
         default: sense_clip = (limit_sense_voltage > 8'h32) ? 8'h32 : limit_sense_voltage;
      endcase
   end

   always_comb begin
      next_blank_cnt = blank_cnt;
      next_viol_seen = viol_seen;
      next_viol_cnt = viol_cnt;
      next_ocl = overcurrent_limit;
      if (sw_edge) begin
         next_blank_cnt = blank_cyc;
      end else if (blank_cnt != 8'h00) begin
         next_blank_cnt = blank_cnt - 8'h01;
      end else if (sense_clip >= thr_mv) begin
         next_viol_seen = 1'b1;
      end
      if (period_start) begin
         next_viol_seen = 1'b0;
         if (viol_seen) begin
            if (viol_cnt != {VIOL_W{1'b1}}) begin
               next_viol_cnt = viol_cnt + 1'b1;
            end
            if (viol_cnt >= viol_allowed) begin
               next_ocl = 1'b1;
            end
         end else begin
            next_viol_cnt = '0;
            next_ocl = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blank_cnt <= 8'h00;
         viol_cnt <= '0;
         viol_seen <= 1'b0;
         overcurrent_limit <= 1'b0;
      end else begin
         blank_cnt <= next_blank_cnt;
         viol_cnt <= next_viol_cnt;
         viol_seen <= next_viol_seen;
         overcurrent_limit <= next_ocl;
      end
   end

   // ---------------------------------------------------------------------------
   // auto-compensation sequencer
   // ---------------------------------------------------------------------------
   logic first_done, next_first_done, store_next, next_store_next;
   logic next_comp_start, next_nv_write, next_pg;
   logic [accl_pkg::COEFF_W-1:0] next_nv_wdata, next_active;
   logic [7:0] us_cnt, next_us_cnt;
   logic [25:0] per_cnt, next_per_cnt;
   logic [accl_pkg::COEFF_W+6:0] scaled;

   assign stored = nv_coeff;
   assign scaled = ((accl_pkg::COEFF_W+7)'(comp_result) * (accl_pkg::COEFF_W+7)'(cfg.gain_pct)) /
      (accl_pkg::COEFF_W+7)'(accl_pkg::GAIN_FULL_PCT);

   always_comb begin
      next_state = state;
      next_first_done = first_done;
      next_store_next = store_next | (trig & cfg.store & output_enabled);
      next_store_valid = store_valid;
      next_comp_start = 1'b0;
      next_nv_write = 1'b0;
      next_nv_wdata = nv_wdata;
      next_active = active_coeff;
      next_pg = power_good_out;
      next_us_cnt = us_cnt;
      next_per_cnt = per_cnt;
      if (!output_enabled) begin
         next_state = accl_pkg::ST_IDLE;
         next_first_done = 1'b0;
         next_pg = 1'b0;
         next_active = (cfg.enable && store_valid) ? stored : user_coeff;
      end else begin
         case (state)
            accl_pkg::ST_IDLE: begin
               if (ramp_done) begin
                  if (cfg.enable && (!store_valid || store_next)) begin
                     next_state = accl_pkg::ST_RUN;
                     next_comp_start = 1'b1;
                  end else begin
                     next_state = accl_pkg::ST_REG;
                     next_first_done = 1'b1;
                  end
               end
            end
            accl_pkg::ST_RUN: begin
               if (comp_done) begin
                  next_state = accl_pkg::ST_REG;
                  next_active = scaled[accl_pkg::COEFF_W-1:0];
                  next_first_done = 1'b1;
                  next_per_cnt = '0;
                  next_us_cnt = 8'h00;
                  if (cfg.store && (!first_done || store_next)) begin
                     next_nv_write = 1'b1;
                     next_nv_wdata = scaled[accl_pkg::COEFF_W-1:0];
                     next_store_valid = 1'b1;
                     next_store_next = 1'b0;
                  end
               end
            end
            accl_pkg::ST_REG: begin
               if (cfg.enable && (cfg.repeat_run || store_next)) begin
                  if (us_cnt == 8'(accl_pkg::TICK_US_CYC - 1)) begin
                     next_us_cnt = 8'h00;
                     next_per_cnt = per_cnt + 26'h1;
                  end else begin
                     next_us_cnt = us_cnt + 8'h01;
                  end
                  if (store_next || per_cnt >= (cfg.minute_period ? 26'(US_PER_1MIN) :
                        26'(US_PER_1S))) begin
                     next_state = accl_pkg::ST_RUN;
                     next_comp_start = 1'b1;
                  end
               end
            end
            default: next_state = accl_pkg::ST_IDLE;
         endcase
         if (cfg.enable && cfg.pg_after_comp) begin
            if (next_first_done) begin
               next_pg = 1'b1;
            end
         end else if (pg_delay_done) begin
            next_pg = 1'b1;
         end
      end
      if (!cfg.store) begin
         next_store_valid = 1'b0;
         next_store_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= accl_pkg::ST_IDLE;
         first_done <= 1'b0;
         store_next <= 1'b0;
         store_valid <= 1'b0;
         comp_start <= 1'b0;
         nv_write <= 1'b0;
         nv_wdata <= '0;
         active_coeff <= '0;
         power_good_out <= 1'b0;
         us_cnt <= 8'h00;
         per_cnt <= '0;
      end else begin
         state <= next_state;
         first_done <= next_first_done;
         store_next <= next_store_next;
         store_valid <= next_store_valid;
         comp_start <= next_comp_start;
         nv_write <= next_nv_write;
         nv_wdata <= next_nv_wdata;
         active_coeff <= next_active;
         power_good_out <= next_pg;
         us_cnt <= next_us_cnt;
         per_cnt <= next_per_cnt;
      end
   end

   // ---------------------------------------------------------------------------
   // fast-transient path
   // ---------------------------------------------------------------------------
   accl_pkg::accl_drive_t next_ftp;
   always_comb begin
      next_ftp = '0;
      if (output_enabled && below_lower_limit) begin
         next_ftp.upper_on = 1'b1;
         next_ftp.bypass = 1'b1;
      end else if (output_enabled && above_upper_limit) begin
         next_ftp.lower_on = 1'b1;
         next_ftp.bypass = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_transient_path <= '0;
      end else begin
         fast_transient_path <= next_ftp;
      end
   end
endmodule // accl_ctrl

// ===== bench/accl_far_model.sv
// far-side model: compensation engine and nonvolatile coefficient store
module accl_far_model #(
   parameter int LAT = 6
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic comp_start,
   input wire logic nv_write,
   input wire logic [15:0] nv_wdata,
   output logic comp_done,
   output logic [15:0] comp_result,
   output logic [15:0] nv_coeff,
   output logic [7:0] runs
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] res = 16'h1000;
   initial begin
      comp_done = 1'b0;
      comp_result = 16'hffff;
      nv_coeff = 16'h0000;
      runs = 8'h00;
   end
   // ---------------------------------------------------------------------------
   // engine: each run yields a new result after a latency
   // ---------------------------------------------------------------------------
   always @(posedge clk) begin
      if (rst_n && comp_start) begin
         repeat (LAT) @(posedge clk);
         comp_done <= 1'b1;
         comp_result <= res;
         @(posedge clk);
         comp_done <= 1'b0;
         comp_result <= ~res;
         res <= res + 16'h0100;
         runs <= runs + 8'h01;
      end
   end
   // ---------------------------------------------------------------------------
   // store: survives reset, returns last written value
   // ---------------------------------------------------------------------------
   always @(posedge clk) begin
      if (nv_write) begin
         nv_coeff <= nv_wdata;
      end
   end
endmodule // accl_far_model

// ===== bench/accl_ctrl_sva.sv
// checker for the current-limit and compensation control block
module accl_ctrl_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic below_lower_limit,
   input wire logic above_upper_limit,
   input wire logic period_start,
   input wire logic comp_done,
   input wire logic output_enabled,
   input wire logic nv_write,
   input wire logic power_good_out,
   input wire logic overcurrent_limit,
   input accl_pkg::accl_drive_t fast_transient_path
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic ext = below_lower_limit || above_upper_limit;
   property p_up; output_enabled && below_lower_limit |=> fast_transient_path.upper_on;
   endproperty
   a_up: assert property (p_up) else $error("upper switch not forced");
   property p_lo; output_enabled && above_upper_limit && !below_lower_limit |=>
      fast_transient_path.lower_on;
   endproperty
   a_lo: assert property (p_lo) else $error("lower switch not forced");
   property p_excl; !(fast_transient_path.upper_on && fast_transient_path.lower_on); endproperty
   a_excl: assert property (p_excl) else $error("both switches forced");
   property p_byp; output_enabled && ext |=> fast_transient_path.bypass; endproperty
   a_byp: assert property (p_byp) else $error("no bypass outside limits");
   property p_nobyp; !ext |=> !fast_transient_path.bypass; endproperty
   a_nobyp: assert property (p_nobyp) else $error("bypass inside limits");
   property p_ocl; $rose(overcurrent_limit) |-> $past(period_start); endproperty
   a_ocl: assert property (p_ocl) else $error("limit fault off period boundary");
   property p_nvw; nv_write |-> $past(comp_done); endproperty
   a_nvw: assert property (p_nvw) else $error("store write without a run");
   property p_nvp; nv_write |=> !nv_write; endproperty
   a_nvp: assert property (p_nvp) else $error("store write not a pulse");
   property p_pg; !output_enabled |=> !power_good_out; endproperty
   a_pg: assert property (p_pg) else $error("power good while disabled");
endmodule // accl_ctrl_sva
bind accl_ctrl accl_ctrl_sva u_sva (.clk(clk), .rst_n(rst_n),
   .below_lower_limit(below_lower_limit), .above_upper_limit(above_upper_limit),
   .period_start(period_start), .comp_done(comp_done), .output_enabled(output_enabled),
   .nv_write(nv_write), .power_good_out(power_good_out),
   .overcurrent_limit(overcurrent_limit), .fast_transient_path(fast_transient_path));

// ===== bench/accl_ctrl_tb.sv
// testbench for the current-limit and compensation control block
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module accl_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, strap_sample = 0, sw_edge = 0;
   logic period_start = 0, output_enabled = 0, ramp_done = 0, pg_delay_done = 0;
   logic below_lower_limit = 0, above_upper_limit = 0, comp_start, nv_write, comp_done;
   logic pready, pslverr, power_good_out, overcurrent_limit, err;
   logic [7:0] paddr = 8'h00, limit_sense_voltage = 8'h00, runs;
   logic [5:0] comp_config_strap = 6'h02;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] comp_result, nv_coeff, nv_wdata, active_coeff;
   accl_pkg::accl_drive_t fast_transient_path;
   int error_cnt = 0, checks = 0;
   always #2 clk = ~clk;
   accl_ctrl #(.US_PER_1S(5), .US_PER_1MIN(5)) dut (.clk, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .comp_config_strap, .strap_sample,
      .sw_edge, .period_start, .limit_sense_voltage, .output_enabled, .ramp_done,
      .pg_delay_done, .comp_done, .comp_result, .nv_coeff, .below_lower_limit,
      .above_upper_limit, .comp_start, .nv_write, .nv_wdata, .active_coeff,
      .power_good_out, .overcurrent_limit, .fast_transient_path);
   accl_far_model far (.clk, .rst_n, .comp_start, .nv_write, .nv_wdata, .comp_done,
      .comp_result, .nv_coeff, .runs);
   // ---------------------------------------------------------------------------
   // bus and stimulus tasks
   // ---------------------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic period(input logic [7:0] v);
      limit_sense_voltage <= v;
      @(posedge clk) sw_edge <= 1'b1;
      @(posedge clk) sw_edge <= 1'b0;
      repeat (6) @(posedge clk);
      period_start <= 1'b1;
      limit_sense_voltage <= 8'h00;
      @(posedge clk) period_start <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic ramp(input int n);
      output_enabled <= 1'b0; ramp_done <= 1'b0; pg_delay_done <= 1'b0;
      repeat (3) @(posedge clk);
      output_enabled <= 1'b1; ramp_done <= 1'b1; pg_delay_done <= 1'b1;
      repeat (n) @(posedge clk);
   endtask
   task automatic results;
      if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100us;
      error_cnt++;
      results();
   end
   // ---------------------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      apb(0, accl_pkg::OFS_OVERCURRENT_LIMIT_CFG, 0);
      `CHK(rd, {8'h00, 8'(accl_pkg::BLANK_CYC), 8'h72, 8'h32})
      for (int r = 0; r < 2; r++) begin
         apb(1, accl_pkg::OFS_OVERCURRENT_LIMIT_CFG, 32'h0002_101e | (r << 8));
         for (int p = 0; p < 3; p++) begin
            period(8'h28);
            `CHK(overcurrent_limit, 1'(r == 1 && p >= 1))
         end
         period(8'h00);
         `CHK(overcurrent_limit, 1'b0)
      end
      output_enabled <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         {above_upper_limit, below_lower_limit} <= 2'(i);
         repeat (2) @(posedge clk);
         `CHK(fast_transient_path, {1'(i == 1), 1'(i == 2), 1'(i != 0)})
      end
      {above_upper_limit, below_lower_limit} <= 2'b00;
      output_enabled <= 1'b0;
      @(posedge clk) strap_sample <= 1'b1;
      @(posedge clk) strap_sample <= 1'b0;
      ramp(3);
      `CHK(power_good_out, 1'b0)
      for (int i = 0; i < 300 && power_good_out !== 1'b1; i++) @(posedge clk);
      @(posedge clk);
      `CHK(power_good_out, 1'b1)
      `CHK(active_coeff, 16'h1000)
      apb(0, accl_pkg::OFS_COEFF_RD, 0);
      `CHK(rd, 32'h0000_1000)
      apb(1, accl_pkg::OFS_COMP_CFG, 32'h6411);
      apb(0, accl_pkg::OFS_STATUS, 0);
      `CHK(rd[5:4], 2'b11)
      output_enabled <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(power_good_out, 1'b0)
      ramp(20);
      `CHK(runs, 8'h01)
      `CHK(active_coeff, 16'h1000)
      apb(1, accl_pkg::OFS_COMP_CFG, 32'h3213);
      apb(1, accl_pkg::OFS_COMP_CMD, 32'h1);
      ramp(1);
      for (int i = 0; i < 300 && nv_write !== 1'b1; i++) @(posedge clk);
      repeat (2) @(posedge clk);
      `CHK(runs, 8'h02)
      `CHK(active_coeff, 16'h0880)
      output_enabled <= 1'b0;
      repeat (3) @(posedge clk);
      apb(1, accl_pkg::OFS_COMP_CFG, 32'h6400);
      apb(1, accl_pkg::OFS_USER_COEFF, 32'h0abc);
      ramp(20);
      `CHK(active_coeff, 16'h0abc)
      `CHK(runs, 8'h02)
      `CHK(power_good_out, 1'b1)
      apb(0, 8'h20, 0);
      `CHK(err, 1'b1)
      results();
   end
endmodule // accl_ctrl_tb
